//--- src/sbtc_params.svh
// Purpose: offsets, fields, reset values and counts of the sixteen-bit timer/counter
// Assumes: apb with 32-bit data, one register per aligned word
// Notes: included by the top module only, not by the package
`ifndef SBTC_PARAMS_SVH
`define SBTC_PARAMS_SVH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define SBTC_ADDR_CONTROL 12'h000
`define SBTC_ADDR_COUNT_LOW 12'h004
`define SBTC_ADDR_COUNT_HIGH 12'h008
`define SBTC_ADDR_IRQ 12'h00c
`define SBTC_ADDR_PORT 12'h010
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define SBTC_BIT_WIDE 7
`define SBTC_BIT_SYSCLK 6
`define SBTC_BIT_PS_HI 5
`define SBTC_BIT_PS_LO 4
`define SBTC_BIT_OSC_EN 3
`define SBTC_BIT_SYNC_DIS 2
`define SBTC_BIT_CS 1
`define SBTC_BIT_RUN 0
`define SBTC_CONTROL_RESET 8'h00
// irq register: bit 0 flag, bit 1 enable
`define SBTC_BIT_FLAG 0
`define SBTC_BIT_IRQ_EN 1
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SBTC_CLOCKS_PER_INSTR 4
`endif

//--- src/sbtc_pkg.sv
// Purpose: types of the sixteen-bit timer/counter
// Assumes: nothing
// Notes: constants live in sbtc_params.svh
package sbtc_pkg;
  typedef enum logic [1:0] {SBTC_TIMER, SBTC_SYNC_COUNTER, SBTC_ASYNC_COUNTER} sbtc_mode_t;
  typedef logic [1:0] sbtc_prescale_t;
endpackage

//--- src/sbtc_timer.sv
// Purpose: sixteen-bit timer/counter with prescaler behind an apb slave
// Assumes: inputs synchronous to CLOCK; oscillator edges arrive as a level on OSC_IN_PIN
// Notes: raw (async) counting is modelled by sampling the edge once, without the two-flop delay
`include "sbtc_params.svh"
module sbtc_timer #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic ARST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // link pins
  input wire logic EXT_COUNT_CLOCK_PIN,
  input wire logic OSC_IN_PIN,
  output logic OSC_OUT_PIN_OUT,
  output logic OSC_OUT_PIN_OE,
  output logic OSC_IN_PIN_OE,
  // system
  input wire logic SPECIAL_EVENT_TRIGGER,
  input wire logic SYSCLK_FROM_LP_OSC_IN,
  input wire logic POWER_MANAGED_MODE,
  output logic LP_OSC_RUNNING,
  output logic OVERFLOW_IRQ
);
  import sbtc_pkg::*;

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (ADDR_W < 5 || ADDR_W > 12) begin : g_addr_w_check
    $error("ADDR_W must lie between 5 and 12");
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [7:0] counter_control_reg;
  logic [15:0] count;
  logic [7:0] high_buffer;
  logic [7:0] high_read_latch;
  logic overflow_flag;
  logic overflow_irq_enable;
  wire access_done = PSEL && PENABLE;
  wire setup = PSEL && !PENABLE;
  wire wr = access_done && PWRITE;
  wire rd = setup && !PWRITE;
  wire [11:0] addr = 12'(PADDR);
  wire hit_ctrl = addr == `SBTC_ADDR_CONTROL;
  wire hit_low = addr == `SBTC_ADDR_COUNT_LOW;
  wire hit_high = addr == `SBTC_ADDR_COUNT_HIGH;
  wire hit_irq = addr == `SBTC_ADDR_IRQ;
  wire hit_port = addr == `SBTC_ADDR_PORT;
  wire mapped = hit_ctrl || hit_low || hit_high || hit_irq || hit_port;
  wire wide_access_mode = counter_control_reg[`SBTC_BIT_WIDE];
  wire lp_osc_enable = counter_control_reg[`SBTC_BIT_OSC_EN];
  wire sysclk_from_lp_osc = SYSCLK_FROM_LP_OSC_IN && lp_osc_enable;
  wire [1:0] prescale_select = counter_control_reg[`SBTC_BIT_PS_HI:`SBTC_BIT_PS_LO];
  wire ext_sync_disable = counter_control_reg[`SBTC_BIT_SYNC_DIS];
  wire clock_source_select = counter_control_reg[`SBTC_BIT_CS];
  wire counter_run = counter_control_reg[`SBTC_BIT_RUN];
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_low = wr && hit_low;
  wire wr_high = wr && hit_high;
  wire rd_low = rd && hit_low;
  wire wr_irq = wr && hit_irq;

  // ----------------------------------------------------------------
  // mode and clock source
  // ----------------------------------------------------------------
  sbtc_mode_t mode;
  assign mode = !clock_source_select ? SBTC_TIMER :
                (ext_sync_disable ? SBTC_ASYNC_COUNTER : SBTC_SYNC_COUNTER);
  // oscillator replaces the pin when enabled
  wire ext_source = lp_osc_enable ? OSC_IN_PIN : EXT_COUNT_CLOCK_PIN;
  logic ext_prev;
  wire ext_rise = ext_source && !ext_prev;

  // instruction-cycle enable from clock/4
  logic [1:0] instr_div;
  wire instr_tick = instr_div == 2'(`SBTC_CLOCKS_PER_INSTR - 1);
  wire source_tick = (mode == SBTC_TIMER) ? instr_tick : ext_rise;

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  logic [2:0] prescale_cnt;
  wire [2:0] prescale_top = (3'h1 << prescale_select) - 3'h1;
  wire prescale_out = counter_run && source_tick && (prescale_cnt == prescale_top);

  // synchroniser for prescaled external edges
  logic sync_a;
  logic sync_b;
  logic sync_b_prev;
  wire sync_pulse = sync_b && !sync_b_prev;
  wire inc_now = (mode == SBTC_SYNC_COUNTER) ? sync_pulse : prescale_out;

  // ----------------------------------------------------------------
  // count next value
  // ----------------------------------------------------------------
  wire [15:0] write_value = wide_access_mode ? {high_buffer, PWDATA[7:0]} : {count[15:8], PWDATA[7:0]};
  wire overflow = inc_now && counter_run && (count == 16'hffff);
  logic [15:0] next_count;
  always_comb begin
    if (wr_low) begin
      next_count = write_value;
    end else if (wr_high && !wide_access_mode) begin
      next_count = {PWDATA[7:0], count[7:0]};
    end else if (SPECIAL_EVENT_TRIGGER) begin
      next_count = 16'h0000;
    end else if (inc_now && counter_run) begin
      next_count = count + 16'h0001;
    end else begin
      next_count = count;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [7:0] ctrl_read = {counter_control_reg[7], sysclk_from_lp_osc, counter_control_reg[5:0]};
  wire [7:0] high_read = wide_access_mode ? high_read_latch : count[15:8];
  wire [1:0] port_read = lp_osc_enable ? 2'h0 : {OSC_IN_PIN, EXT_COUNT_CLOCK_PIN};
  wire [31:0] next_prdata = hit_ctrl ? {24'h0, ctrl_read} :
                            hit_low ? {24'h0, count[7:0]} :
                            hit_high ? {24'h0, high_read} :
                            hit_irq ? {30'h0, overflow_irq_enable, overflow_flag} :
                            hit_port ? {30'h0, port_read} : 32'h0;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      counter_control_reg <= `SBTC_CONTROL_RESET;
    end else if (wr_ctrl) begin
      counter_control_reg <= {PWDATA[7], 1'b0, PWDATA[5:0]};
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      count <= 16'h0000;
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      high_buffer <= 8'h00;
    end else if (wr_high) begin
      high_buffer <= PWDATA[7:0];
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      high_read_latch <= 8'h00;
    end else if (rd_low) begin
      high_read_latch <= count[15:8];
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      overflow_flag <= 1'b0;
    end else if (overflow) begin
      overflow_flag <= 1'b1;
    end else if (wr_irq) begin
      overflow_flag <= PWDATA[`SBTC_BIT_FLAG];
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      overflow_irq_enable <= 1'b0;
    end else if (wr_irq) begin
      overflow_irq_enable <= PWDATA[`SBTC_BIT_IRQ_EN];
    end
  end

  // ----------------------------------------------------------------
  // dividers and edge state
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_tick ? 2'h0 : instr_div + 2'h1;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_source;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      prescale_cnt <= 3'h0;
    end else if (wr_low || !counter_run) begin
      prescale_cnt <= 3'h0;
    end else if (source_tick) begin
      prescale_cnt <= (prescale_cnt >= prescale_top) ? 3'h0 : prescale_cnt + 3'h1;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_b_prev <= 1'b0;
    end else begin
      sync_a <= prescale_out;
      sync_b <= sync_a;
      sync_b_prev <= sync_b;
    end
  end

  // ----------------------------------------------------------------
  // output next values
  // ----------------------------------------------------------------
  wire next_pready = setup;
  wire next_pslverr = setup && !mapped;
  wire next_osc_out_pin_out = lp_osc_enable && !OSC_IN_PIN;
  wire next_lp_osc_running = lp_osc_enable || (lp_osc_enable && POWER_MANAGED_MODE);
  wire next_overflow_irq = (overflow_flag || overflow) && overflow_irq_enable;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= 32'h0;
    end else if (rd) begin
      PRDATA <= next_prdata;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= next_pready;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      PSLVERR <= 1'b0;
    end else begin
      PSLVERR <= next_pslverr;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      OSC_OUT_PIN_OUT <= 1'b0;
    end else begin
      OSC_OUT_PIN_OUT <= next_osc_out_pin_out;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      OSC_OUT_PIN_OE <= 1'b0;
    end else begin
      OSC_OUT_PIN_OE <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      OSC_IN_PIN_OE <= 1'b0;
    end else begin
      OSC_IN_PIN_OE <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      LP_OSC_RUNNING <= 1'b0;
    end else begin
      LP_OSC_RUNNING <= next_lp_osc_running;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      OVERFLOW_IRQ <= 1'b0;
    end else begin
      OVERFLOW_IRQ <= next_overflow_irq;
    end
  end

endmodule // sbtc_timer

//--- verif/sbtc_timer_monitor.sv
// Purpose: port checker for sbtc_timer
// Assumes: apb answer one cycle after setup
// Notes: bound at the foot
module sbtc_timer_monitor #(
  parameter int ADDR_W = 12
) (
  // clock, reset and apb
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // pins and system
  input wire logic OSC_IN_PIN,
  input wire logic OSC_OUT_PIN_OUT,
  input wire logic OSC_OUT_PIN_OE,
  input wire logic OSC_IN_PIN_OE,
  input wire logic POWER_MANAGED_MODE,
  input wire logic LP_OSC_RUNNING,
  input wire logic OVERFLOW_IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  wire acc = PSEL && PENABLE;
  wire ctl_wr = acc && PWRITE && PADDR == 12'h000;
  wire port_rd = acc && !PWRITE && PADDR == 12'h010;
  wire unmapped = PADDR > 12'h010 || PADDR[1:0] != 2'h0;
  sequence setup_s; PSEL && !PENABLE; endsequence
  sequence access_s; PSEL && PENABLE && PREADY; endsequence
  property osc_follow_p; logic b; (ctl_wr, b = PWDATA[3]) |-> ##2 LP_OSC_RUNNING == b; endproperty
  answer_one_cycle_a: assert property (setup_s |=> access_s) else $error("no answer after setup");
  ready_in_access_a: assert property (PREADY |-> acc) else $error("ready outside access");
  unmapped_refused_a: assert property (acc && unmapped |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
    else $error("unmapped access not refused");
  error_with_ready_a: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  pins_input_only_a: assert property (!OSC_OUT_PIN_OE && !OSC_IN_PIN_OE) else $error("shared pin driven");
  osc_enable_a: assert property (osc_follow_p) else $error("oscillator state off enable bit");
  osc_keeps_running_a: assert property (POWER_MANAGED_MODE && LP_OSC_RUNNING && !ctl_wr && !$past(ctl_wr)
    |=> LP_OSC_RUNNING) else $error("oscillator stopped in power-managed mode");
  amp_output_a: assert property (OSC_OUT_PIN_OUT == (LP_OSC_RUNNING && !$past(OSC_IN_PIN)))
    else $error("amplifier output wrong");
  port_reads_zero_a: assert property (port_rd && LP_OSC_RUNNING |-> PRDATA[1:0] == 2'h0)
    else $error("shared pins read nonzero");
  reset_quiet_a: assert property ($rose(ARST_N) |-> !PREADY && !LP_OSC_RUNNING && !OVERFLOW_IRQ)
    else $error("outputs active after reset");
endmodule // sbtc_timer_monitor
bind sbtc_timer sbtc_timer_monitor #(.ADDR_W(ADDR_W)) sbtc_timer_monitor_i (.CLOCK(CLOCK), .ARST_N(ARST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .OSC_IN_PIN(OSC_IN_PIN), .OSC_OUT_PIN_OUT(OSC_OUT_PIN_OUT),
  .OSC_OUT_PIN_OE(OSC_OUT_PIN_OE), .OSC_IN_PIN_OE(OSC_IN_PIN_OE), .POWER_MANAGED_MODE(POWER_MANAGED_MODE),
  .LP_OSC_RUNNING(LP_OSC_RUNNING), .OVERFLOW_IRQ(OVERFLOW_IRQ));

//--- verif/sbtc_clock_source.sv
// Purpose: external count clock and crystal stand-in
// Assumes: one rising edge every four cycles while run
// Notes: only the selected pin toggles, the other rests low
module sbtc_clock_source (
  // control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic use_osc,
  // pins and edge count
  output logic ext_pin,
  output logic osc_pin,
  output int edges
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 2'h0;
      edges <= 0;
    end else if (run) begin
      ph <= ph + 2'h1;
      edges <= edges + int'(ph == 2'h1);
    end
  end
  assign ext_pin = !use_osc && ph[1];
  assign osc_pin = use_osc && ph[1];
endmodule // sbtc_clock_source

//--- verif/sbtc_timer_tb_top.sv
// Purpose: self-checking bench of sbtc_timer
// Assumes: apb answer one cycle after setup
// Notes: reads queue expectations, a monitor process compares them
module sbtc_timer_tb_top;
  import sbtc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, arst_n = 0, psel = 0, pen = 0, pwr = 0, sev = 0, sys = 1, pmm = 0, src_run = 0, src_osc = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, ext_pin, osc_pin, irq;
  int edges, miscompares = 0, n_tests = 0, seed = 32'h06f9fba3;
  logic [32:0] expq[$];
  int tolq[$];
  sbtc_timer sbtc_timer_i (.CLOCK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_COUNT_CLOCK_PIN(ext_pin), .OSC_IN_PIN(osc_pin), .OSC_OUT_PIN_OUT(), .OSC_OUT_PIN_OE(),
    .OSC_IN_PIN_OE(), .SPECIAL_EVENT_TRIGGER(sev), .SYSCLK_FROM_LP_OSC_IN(sys),
    .POWER_MANAGED_MODE(pmm), .LP_OSC_RUNNING(), .OVERFLOW_IRQ(irq));
  sbtc_clock_source sbtc_clock_source_i (.clk(clk), .rst_n(arst_n), .run(src_run), .use_osc(src_osc),
    .ext_pin(ext_pin), .osc_pin(osc_pin), .edges(edges));
  initial forever #50 clk = ~clk;
  task automatic end_sim();
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(string what, logic [32:0] seen, logic [32:0] exp, int tol);
    n_tests++;
    if (seen !== exp && ($isunknown(seen) || (seen > exp ? seen - exp : exp - seen) > tol)) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic [32:0] e, int t, logic trig);
    int n;
    if (!wr) begin
      expq.push_back(e);
      tolq.push_back(t);
    end
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    sev <= trig;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) begin
      miscompares++;
      end_sim();
    end
    psel <= 1'b0;
    pen <= 1'b0;
    sev <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 0, 1'b0);
  endtask
  task automatic rd(logic [11:0] a, logic [32:0] e, int t = 0);
    apb(1'b0, a, 32'h0, e, t, 1'b0);
  endtask
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1 && !pwr && expq.size() > 0) begin
      check("read data", {pslverr, prdata}, expq.pop_front(), tolq.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(12'h000, 33'h0);
    wr(12'h000, 32'hf4);
    rd(12'h000, 33'hb4);
    wr(12'h008, 32'h5a);
    rd(12'h004, 33'h0);
    rd(12'h008, 33'h0);
    wr(12'h004, 32'hc3);
    rd(12'h004, 33'hc3);
    rd(12'h008, 33'h5a);
    sev <= 1'b1;
    @(posedge clk);
    sev <= 1'b0;
    rd(12'h004, 33'h0);
    apb(1'b1, 12'h004, 32'h77, 33'h0, 0, 1'b1);
    rd(12'h004, 33'h77);
    for (int ps = 0; ps < 4; ps++) begin
      wr(12'h000, 32'h0);
      wr(12'h004, 32'h0);
      wr(12'h008, 32'h0);
      wr(12'h000, (32'(ps) << 4) | (32'($random(seed)) & 32'h4) | 32'h1);
      repeat ((32 << ps) - 2) @(posedge clk);
      wr(12'h000, 32'h0);
      rd(12'h004, 33'd8, 1);
    end
    for (int m = 0; m < 3; m++) begin
      int first_edge;
      first_edge = edges;
      wr(12'h004, 32'h0);
      wr(12'h008, 32'h0);
      wr(12'h000, m == 2 ? 32'h0b : (m == 1 ? 32'h07 : 32'h03));
      src_osc <= (m == 2);
      pmm <= (m == 2);
      repeat (m == 2 ? 20 : 1) @(posedge clk);
      src_run <= 1'b1;
      repeat (40) @(posedge clk);
      src_run <= 1'b0;
      repeat (6) @(posedge clk);
      check("partner edges", 33'(edges - first_edge), 33'd10, 0);
      rd(12'h004, 33'(edges - first_edge));
    end
    rd(12'h000, 33'h4b);
    rd(12'h010, 33'h0);
    wr(12'h000, 32'h80);
    pmm <= 1'b0;
    wr(12'h008, 32'hff);
    wr(12'h004, 32'hff);
    wr(12'h00c, 32'h2);
    wr(12'h000, 32'h81);
    repeat (12) @(posedge clk);
    wr(12'h000, 32'h80);
    rd(12'h00c, 33'h3);
    check("irq pin", {32'h0, irq}, 33'h1, 0);
    wr(12'h00c, 32'h2);
    rd(12'h00c, 33'h2);
    check("irq pin", {32'h0, irq}, 33'h0, 0);
    wr(12'h014, 32'hff);
    rd(12'h014, 33'h100000000);
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule // sbtc_timer_tb_top
